// [logic/ssmul_defs.svh]
`ifndef SSMUL_DEFS_SVH
`define SSMUL_DEFS_SVH

// Instruction word field positions
`define SSMUL_MAJOR_HI 31
`define SSMUL_MAJOR_LO 26
`define SSMUL_RD_HI    15
`define SSMUL_RD_LO    11
`define SSMUL_SUB_HI   10
`define SSMUL_SUB_LO   6
`define SSMUL_FUNC_HI  5
`define SSMUL_FUNC_LO  0

// Opcode values
`define SSMUL_MAJOR_GRP3   6'h1F
`define SSMUL_FUNC_QUAD    6'h10
`define SSMUL_FUNC_OCTAL   6'h14
`define SSMUL_SUB_LEFT     5'h06
`define SSMUL_SUB_RIGHT    5'h07
`define SSMUL_SUB_FRACRND  5'h1F

// Arithmetic constants
`define SSMUL_SAT_U16  16'hFFFF
`define SSMUL_Q15_NEG1 16'h8000
`define SSMUL_Q15_MAX  16'h7FFF
`define SSMUL_Q15_RND  32'h00008000

// Overflow bit of the DSP control register and its reset value
`define SSMUL_OVF_BIT   21
`define SSMUL_OVF_RESET 1'h0

`endif

// [logic/ssmul_pkg.sv]
package ssmul_pkg;

   // Operations this datapath executes
   typedef enum logic [2:0] {
      OP_NONE,
      OP_RPAIR,
      OP_LQUAD,
      OP_RQUAD,
      OP_QPAIR
   } ssmul_op_type;

   // Issue request from the pipeline
   typedef struct packed {
      logic        valid;
      logic [31:0] instr;
      logic [63:0] rsVal;
      logic [63:0] rtVal;
   } ssmul_req_type;

   // Registered answer to the pipeline
   typedef struct packed {
      logic        valid;
      logic [4:0]  rdIdx;
      logic [63:0] value;
      logic        resvExc;
      logic        dspOffExc;
      logic        ovfSet;
   } ssmul_res_type;

endpackage : ssmul_pkg

// [logic/ssmul_lane.sv]
`timescale 1ns/1ps
`include "ssmul_defs.svh"

// One 16-bit lane: unsigned byte x halfword with saturation,
// or signed Q15 x Q15 with rounding and saturation
module ssmul_lane (
   input  wire logic [7:0]  byteIn,
   input  wire logic [15:0] halfRs,
   input  wire logic [15:0] halfRt,
   input  wire logic        fracMode,
   output logic      [15:0] laneRes,
   output logic             laneSat
);
   logic [23:0] prodU;    // Unsigned 24-bit product
   logic [31:0] prodS;    // Signed 32-bit product
   logic [31:0] rounded;  // Shifted and rounded Q31 value

   // Lane arithmetic
   always_comb begin
      prodU   = 24'(byteIn) * 24'(halfRt);
      prodS   = 32'($signed(halfRs) * $signed(halfRt));
      rounded = 32'(prodS << 1) + `SSMUL_Q15_RND;
      if (fracMode) begin
         // Both at minus one cannot be represented
         if (halfRs == `SSMUL_Q15_NEG1 && halfRt == `SSMUL_Q15_NEG1) begin
            laneRes = `SSMUL_Q15_MAX;
            laneSat = 1'b1;
         end else begin
            laneRes = rounded[31:16];
            laneSat = 1'b0;
         end
      end else if (prodU[23:16] != 8'h00) begin
         laneRes = `SSMUL_SAT_U16;
         laneSat = 1'b1;
      end else begin
         laneRes = prodU[15:0];
         laneSat = 1'b0;
      end
   end

endmodule : ssmul_lane

// [logic/ssmul_top.sv]
`timescale 1ns/1ps
`include "ssmul_defs.svh"

// Summary of operation
// - Byte times halfword, saturate to all ones.
// - Any saturating lane of the op sets overflow bit 21.
// - Right pair: low bytes, sign-extend upper result.
// - Left quad: upper four bytes, four halfwords.
// - Right quad: lower four bytes, four halfwords.
// - Q15 pair: shift, round, keep high half.
// - Both minus one gives 0x7FFF, sets overflow.
// - Base accumulator may hold anything afterwards.
// - Accumulators one to three stay untouched.
// - No exception ever depends on operand data.
// - Reserved or disabled exceptions from decode only.
// - Quad variants: function 010100, sub 00110/00111.
// - Q15 pair: sub 11111, function 010000.
module ssmul_top (
   input  wire logic                   sys_clk,
   input  wire logic                   reset,
   input  wire ssmul_pkg::ssmul_req_type req,
   input  wire logic                   extPresent,
   input  wire logic                   extEnabled,
   input  wire logic                   ctlWrEn,
   input  wire logic [31:0]            ctlWrData,
   output ssmul_pkg::ssmul_res_type    res,
   output logic                        ctlOvfFlag,
   output logic      [3:0]             accWrMask
);
   import ssmul_pkg::*;

   // Classify an instruction word
   function automatic ssmul_op_type opDecode(input logic [31:0] w);
      logic [5:0] major;
      logic [4:0] sub;
      logic [5:0] func;
      major = w[`SSMUL_MAJOR_HI:`SSMUL_MAJOR_LO];
      sub   = w[`SSMUL_SUB_HI:`SSMUL_SUB_LO];
      func  = w[`SSMUL_FUNC_HI:`SSMUL_FUNC_LO];
      opDecode = OP_NONE;
      if (major == `SSMUL_MAJOR_GRP3) begin
         if (func == `SSMUL_FUNC_OCTAL && sub == `SSMUL_SUB_LEFT)
            opDecode = OP_LQUAD;
         else if (func == `SSMUL_FUNC_OCTAL && sub == `SSMUL_SUB_RIGHT)
            opDecode = OP_RQUAD;
         else if (func == `SSMUL_FUNC_QUAD && sub == `SSMUL_SUB_RIGHT)
            opDecode = OP_RPAIR;
         else if (func == `SSMUL_FUNC_QUAD && sub == `SSMUL_SUB_FRACRND)
            opDecode = OP_QPAIR;
      end
   endfunction : opDecode

   // True for the two-lane operations
   function automatic logic isPair(input ssmul_op_type op);
      isPair = (op == OP_RPAIR) || (op == OP_QPAIR);
   endfunction : isPair

   ssmul_op_type  curOp;          // Decoded op of the issue slot
   logic          issueOk;        // Issue executes this cycle
   logic [7:0]    laneByte [4];   // Byte operand per lane
   logic [15:0]   laneRes  [4];   // Lane results
   logic [3:0]    laneSat;        // Lane saturation flags
   logic [3:0]    laneMask;       // Lanes that belong to the op
   logic          satAny;         // Any active lane saturated
   logic [63:0]   packed64;       // Assembled destination value
   ssmul_res_type res_r;          // Registered answer
   ssmul_res_type res_nxt;
   ssmul_op_type  resOp_r;        // Op of the registered answer
   ssmul_op_type  resOp_nxt;
   logic          ovfFlag_r;      // Overflow bit of control register
   logic          ovfFlag_nxt;

   // Operand steering and lane masking
   always_comb begin
      curOp = req.valid ? opDecode(req.instr) : OP_NONE;
      for (int i = 0; i < 4; i++) begin
         // Left quad reads the upper word bytes, others the lower
         if (curOp == OP_LQUAD)
            laneByte[i] = req.rsVal[32 + 8 * i +: 8];
         else
            laneByte[i] = req.rsVal[8 * i +: 8];
      end
      // Pair ops only own lanes one and zero
      laneMask = isPair(curOp) ? 4'h3 : 4'hF;
   end

   // Four lane datapaths
   for (genvar g = 0; g < 4; g++) begin : gLane
      ssmul_lane uLane (
         .byteIn   (laneByte[g]),
         .halfRs   (req.rsVal[16 * g +: 16]),
         .halfRt   (req.rtVal[16 * g +: 16]),
         .fracMode (curOp == OP_QPAIR),
         .laneRes  (laneRes[g]),
         .laneSat  (laneSat[g])
      );
   end

   // Result assembly and saturation summary
   always_comb begin
      satAny = |(laneSat & laneMask);
      if (isPair(curOp))
         // Upper word is the sign of the upper lane result
         packed64 = {{32{laneRes[1][15]}}, laneRes[1], laneRes[0]};
      else
         packed64 = {laneRes[3], laneRes[2], laneRes[1], laneRes[0]};
   end

   // Next answer: exceptions come from decode and enables only
   always_comb begin
      issueOk   = (curOp != OP_NONE) && extPresent && extEnabled;
      res_nxt   = '0;
      resOp_nxt = OP_NONE;
      if (curOp != OP_NONE) begin
         if (!extPresent) begin
            res_nxt.resvExc = 1'b1;
         end else if (!extEnabled) begin
            res_nxt.dspOffExc = 1'b1;
         end else begin
            // Saturation never traps, it only flags
            res_nxt.valid  = 1'b1;
            res_nxt.rdIdx  = req.instr[`SSMUL_RD_HI:`SSMUL_RD_LO];
            res_nxt.value  = packed64;
            res_nxt.ovfSet = satAny;
            resOp_nxt      = curOp;
         end
      end
   end

   // Answer registers
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         res_r   <= '0;
         resOp_r <= OP_NONE;
      end else begin
         res_r   <= res_nxt;
         resOp_r <= resOp_nxt;
      end
   end

   // Overflow bit: a set in the same cycle as a write wins
   always_comb begin
      ovfFlag_nxt = ovfFlag_r;
      if (ctlWrEn)
         ovfFlag_nxt = ctlWrData[`SSMUL_OVF_BIT];
      if (issueOk && satAny)
         ovfFlag_nxt = 1'b1;
   end

   // Overflow bit register
   always_ff @(posedge sys_clk) begin
      if (reset)
         ovfFlag_r <= `SSMUL_OVF_RESET;
      else
         ovfFlag_r <= ovfFlag_nxt;
   end

   // Outputs; no accumulator is ever written
   assign res        = res_r;
   assign ctlOvfFlag = ovfFlag_r;
   assign accWrMask  = 4'h0;

   // Saturated right-quad lane zero reads all ones
   property p_uSat;
      @(posedge sys_clk) disable iff (reset)
      (issueOk && curOp == OP_RQUAD && (24'(req.rsVal[7:0]) * 24'(req.rtVal[15:0]) > 24'h00FFFF))
      |=> (res_r.value[15:0] == 16'hFFFF) && res_r.ovfSet;
   endproperty
   a_uSat: assert property (p_uSat) else $error("unsigned lane did not saturate");

   // Left quad lane three keeps an in-range product exactly
   property p_lquadLane;
      @(posedge sys_clk) disable iff (reset)
      (issueOk && curOp == OP_LQUAD && (24'(req.rsVal[63:56]) * 24'(req.rtVal[63:48]) <= 24'h00FFFF))
      |=> res_r.value[63:48] == 16'($past(req.rsVal[63:56]) * $past(req.rtVal[63:48]));
   endproperty
   a_lquadLane: assert property (p_lquadLane) else $error("left quad lane three wrong");

   // Pair results carry the upper lane sign in the upper word
   property p_pairSign;
      @(posedge sys_clk) disable iff (reset)
      (res_r.valid && isPair(resOp_r)) |-> res_r.value[63:32] == {32{res_r.value[31]}};
   endproperty
   a_pairSign: assert property (p_pairSign) else $error("pair sign extension wrong");

   // Q15 minus one squared clamps and flags
   property p_q15Clamp;
      @(posedge sys_clk) disable iff (reset)
      (issueOk && curOp == OP_QPAIR && req.rsVal[31:16] == 16'h8000 && req.rtVal[31:16] == 16'h8000)
      |=> (res_r.value[31:16] == 16'h7FFF) && ctlOvfFlag;
   endproperty
   a_q15Clamp: assert property (p_q15Clamp) else $error("Q15 clamp missing");

   // Q15 rounding of lane zero
   property p_q15Round;
      @(posedge sys_clk) disable iff (reset)
      (issueOk && curOp == OP_QPAIR && req.rsVal[15:0] != 16'h8000)
      |=> res_r.value[15:0] == 16'((32'($signed($past(req.rsVal[15:0])) * $signed($past(req.rtVal[15:0])))
                                     * 2 + 32'h00008000) >> 16);
   endproperty
   a_q15Round: assert property (p_q15Round) else $error("Q15 rounding wrong");

   // Overflow bit holds once set unless software writes
   property p_ovfSticky;
      @(posedge sys_clk) disable iff (reset)
      (ctlOvfFlag && !ctlWrEn) |=> ctlOvfFlag;
   endproperty
   a_ovfSticky: assert property (p_ovfSticky) else $error("overflow bit cleared by datapath");

   // Saturation reaches the overflow bit even against a clearing write
   property p_ovfSet;
      @(posedge sys_clk) disable iff (reset)
      (issueOk && satAny) |=> ctlOvfFlag && res_r.ovfSet;
   endproperty
   a_ovfSet: assert property (p_ovfSet) else $error("overflow bit not set");

   // Decode-only exceptions
   property p_exc;
      @(posedge sys_clk) disable iff (reset)
      (curOp != OP_NONE && !(extPresent && extEnabled))
      |=> !res_r.valid && (res_r.resvExc != res_r.dspOffExc) && (res_r.resvExc == !$past(extPresent));
   endproperty
   a_exc: assert property (p_exc) else $error("wrong exception for disabled extension");

   // Enabled issues never trap, whatever the data
   property p_noDataExc;
      @(posedge sys_clk) disable iff (reset)
      issueOk |=> res_r.valid && !res_r.resvExc && !res_r.dspOffExc;
   endproperty
   a_noDataExc: assert property (p_noDataExc) else $error("data dependent trap");

   // Right quad decode leads to a right quad answer
   property p_rquadDecode;
      @(posedge sys_clk) disable iff (reset)
      (req.valid && extPresent && extEnabled && req.instr[31:26] == 6'h1F && req.instr[10:6] == 5'h07
       && req.instr[5:0] == 6'h14) |=> resOp_r == OP_RQUAD;
   endproperty
   a_rquadDecode: assert property (p_rquadDecode) else $error("right quad not decoded");

   // Accumulators are never written
   property p_accKeep;
      @(posedge sys_clk) disable iff (reset)
      res_r.valid |-> accWrMask == 4'h0;
   endproperty
   a_accKeep: assert property (p_accKeep) else $error("accumulator written");

endmodule : ssmul_top

// [test/ssmul_pipe_model.sv]
`timescale 1ns/1ps

// Pipeline side: issue slot, extension state and control register writes
module ssmul_pipe_model (
   input  wire logic                sys_clk,
   output ssmul_pkg::ssmul_req_type req,
   output logic                     extPresent,
   output logic                     extEnabled,
   output logic                     ctlWrEn,
   output logic [31:0]              ctlWrData
);
   import ssmul_pkg::*;

   // Base accumulator copy that software keeps across each multiply
   logic [63:0] savedAcc;

   // Quiet slot with known values from time zero
   initial begin
      req        = '0;
      extPresent = 1'b1;
      extEnabled = 1'b1;
      ctlWrEn    = 1'b0;
      ctlWrData  = '0;
      savedAcc   = '0;
   end

   // Presents one request, called just after a falling edge
   task automatic issue(input logic v, input logic [31:0] ins, input logic [63:0] rs, rt,
                        input logic pres, en, wr, input logic [31:0] wd);
      req        = {v, ins, rs, rt};
      extPresent = pres;
      extEnabled = en;
      ctlWrEn    = wr;
      ctlWrData  = wd;
   endtask : issue

   // Empty slot: lines flip so stale values never look valid
   task automatic idle();
      req       = {1'b0, ~req.instr, ~req.rsVal, ~req.rtVal};
      ctlWrEn   = 1'b0;
      ctlWrData = ~ctlWrData;
   endtask : idle
endmodule : ssmul_pipe_model

// [test/simd_saturating_multiply_test.sv]
`timescale 1ns/1ps

// Self-checking bench for the packed multiply datapath
module simd_saturating_multiply_test;
   import ssmul_pkg::*;

   logic                sys_clk;     // 50 MHz clock
   logic                reset;       // Synchronous, active high
   ssmul_req_type       req;         // Issue slot from the model
   ssmul_res_type       res;         // Answer from the design
   logic                extPresent;  // Extension implemented
   logic                extEnabled;  // Extension turned on
   logic                ctlWrEn;     // Control register write
   logic [31:0]         ctlWrData;   // Control register data
   logic                ctlOvfFlag;  // Overflow flag
   logic [3:0]          accWrMask;   // Accumulator writes
   logic                flagExp;     // Modelled overflow flag
   int                  n_fail;      // Mismatches
   int                  tests_run;   // Comparisons
   int                  cycles;      // Timeout count

   // Sub and function fields per operation, the last code decodes to nothing
   function automatic logic [10:0] opFields(input int op);
      case (op)
         0:       return {5'h07, 6'h10};
         1:       return {5'h06, 6'h14};
         2:       return {5'h07, 6'h14};
         3:       return {5'h1F, 6'h10};
         default: return {5'h00, 6'h3F};
      endcase
   endfunction : opFields

   ssmul_pipe_model pipe (.sys_clk(sys_clk), .req(req), .extPresent(extPresent), .extEnabled(extEnabled),
                          .ctlWrEn(ctlWrEn), .ctlWrData(ctlWrData));
   ssmul_top dut (.sys_clk(sys_clk), .reset(reset), .req(req), .extPresent(extPresent),
                  .extEnabled(extEnabled), .ctlWrEn(ctlWrEn), .ctlWrData(ctlWrData),
                  .res(res), .ctlOvfFlag(ctlOvfFlag), .accWrMask(accWrMask));

   // Clock generator
   initial sys_clk = 1'b0;
   always #10 sys_clk = ~sys_clk;

   // Unsigned byte by halfword, saturation flag on top
   function automatic logic [16:0] ulane(input logic [7:0] b, input logic [15:0] h);
      logic [23:0] p;
      p = b * h;
      return (p[23:16] != 8'h00) ? {1'b1, 16'hFFFF} : {1'b0, p[15:0]};
   endfunction : ulane

   // Signed Q15 product with rounding, saturation flag on top
   function automatic logic [16:0] qlane(input logic [15:0] a, input logic [15:0] b);
      logic signed [31:0] t;
      if (a == 16'h8000 && b == 16'h8000) return {1'b1, 16'h7FFF};
      t = $signed(a) * $signed(b);
      t = (t <<< 1) + 32'sh0000_8000;
      return {1'b0, t[31:16]};
   endfunction : qlane

   // Compares one value and counts
   task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask : chk

   // One cycle: present a request, then check the answer at the next falling edge
   task automatic step(input int op, input logic [63:0] rs, rt, input logic pres, en, wr, wb);
      logic [16:0] l[4];
      logic [63:0] v;
      logic [31:0] r;
      logic [31:0] wd;
      logic        sat;
      logic        take;
      r  = $urandom;
      wd = $urandom;
      wd[21] = wb;
      for (int i = 0; i < 4; i++) begin
         l[i] = (op == 3) ? qlane(rs[16*i+:16], rt[16*i+:16]) :
                ulane((op == 1) ? rs[32+8*i+:8] : rs[8*i+:8], rt[16*i+:16]);
      end
      // Pair operations use lanes 1 and 0 only
      if (op == 0 || op == 3) begin
         v   = {{32{l[1][15]}}, l[1][15:0], l[0][15:0]};
         sat = l[1][16] | l[0][16];
      end else begin
         v   = {l[3][15:0], l[2][15:0], l[1][15:0], l[0][15:0]};
         sat = l[3][16] | l[2][16] | l[1][16] | l[0][16];
      end
      take    = (op < 4) && pres && en;
      flagExp = (take && sat) ? 1'b1 : (wr ? wb : flagExp);
      pipe.issue(1'b1, {6'h1F, r[14:0], opFields(op)}, rs, rt, pres, en, wr, wd);
      @(negedge sys_clk);
      chk("valid", res.valid, take);
      chk("resvExc", res.resvExc, (op < 4) && !pres);
      chk("dspOffExc", res.dspOffExc, (op < 4) && pres && !en);
      chk("ovfSet", res.ovfSet, take && sat);
      chk("ctlOvfFlag", ctlOvfFlag, flagExp);
      chk("accWrMask", accWrMask, 64'h0);
      if (take) begin
         chk("rdIdx", res.rdIdx, r[4:0]);
         chk("value", res.value, v);
      end
   endtask : step

   // Prints counts and verdict, then ends the run
   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // Cuts a hang short
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 20000) begin
         n_fail++;
         stop_test();
      end
   end

   // Main sequence
   initial begin
      reset     = 1'b1;
      n_fail    = 0;
      tests_run = 0;
      cycles    = 0;
      flagExp   = 1'b0;
      void'($urandom(32'h7B259CE2));
      repeat (16) @(negedge sys_clk);
      reset = 1'b0;
      @(negedge sys_clk);
      chk("ovf after reset", ctlOvfFlag, 64'h0);
      // Boundaries, sticky flag, write against saturation
      step(0, 64'h0000_0000_0000_FF02, 64'h0000_0000_FFFF_7FFF, 1, 1, 0, 0);
      step(2, 64'h0000_0000_0101_0101, 64'h0000_00FF_0000_0001, 1, 1, 1, 0);
      step(1, 64'h0201_FF00_0000_0000, 64'h8000_FFFF_0000_1234, 1, 1, 0, 0);
      step(2, 64'h0000_0000_0000_0001, 64'h0000_0000_0000_0001, 1, 1, 0, 0);
      step(3, 64'h0000_0000_8000_8000, 64'h0000_0000_8000_8000, 1, 1, 1, 0);
      step(3, 64'h0000_0000_8000_FFFF, 64'h0000_0000_7FFF_0001, 1, 1, 1, 0);
      step(4, 64'h0, 64'h0, 1, 1, 1, 1);
      step(4, 64'h0, 64'h0, 1, 1, 1, 0);
      $display("test edges done");
      // Missing or disabled extension with saturating data
      step(0, 64'h0000_0000_0000_FFFF, 64'hFFFF_FFFF_FFFF_FFFF, 0, 1, 0, 0);
      step(3, 64'h0000_0000_8000_8000, 64'h0000_0000_8000_8000, 1, 0, 0, 0);
      step(1, 64'hFFFF_FFFF_0000_0000, 64'hFFFF_FFFF_FFFF_FFFF, 0, 0, 0, 0);
      $display("test exceptions done");
      // Random back-to-back traffic across all operations
      repeat (500) begin
         step($urandom % 5, {$urandom, $urandom}, {$urandom, $urandom}, ($urandom % 8) != 0,
              ($urandom % 8) != 0, ($urandom % 6) == 0, $urandom);
      end
      pipe.idle();
      @(negedge sys_clk);
      chk("valid idle", res.valid, 64'h0);
      $display("test random done");
      stop_test();
   end
endmodule : simd_saturating_multiply_test
